// [core/ocpws_map.svh]
`ifndef OCPWS_MAP_SVH
`define OCPWS_MAP_SVH
// Register byte offsets
`define OCPWS_SYSCTL_OFF 12'h000
`define OCPWS_OSCCTL_OFF 12'h004
`define OCPWS_STBYCTL_OFF 12'h008
`define OCPWS_PLL_USE_SELECT_OFF 12'h00C
// Reset values
`define OCPWS_SYSCTL_RST 32'h0001_0000
`define OCPWS_OSCCTL_RST 32'h8001_0000
`define OCPWS_STBYCTL_RST 32'h0000_0103
`define OCPWS_PLL_USE_SELECT_RST 32'h0000_D01E
// Writable bit masks, everything else reads as zero except the warm-up status bit
`define OCPWS_SYSCTL_WMASK 32'h0003_1707
`define OCPWS_OSCCTL_WMASK 32'hFFFF_F30C
`define OCPWS_STBYCTL_WMASK 32'h0003_0307
`define OCPWS_PLL_USE_SELECT_WMASK 32'h0000_F7FF
// Oscillator control fields
`define OCPWS_WU_COUNT_HI 31
`define OCPWS_WU_COUNT_LO 20
`define OCPWS_WU_SRC_BIT 19
`define OCPWS_XPIN_BIT 18
`define OCPWS_OSC_SEL_BIT 17
`define OCPWS_INT_EN_BIT 16
`define OCPWS_EXT_EN_BIT 8
`define OCPWS_PLL_RUN_BIT 2
`define OCPWS_WU_BUSY_BIT 1
`define OCPWS_WU_START_BIT 0
// Standby control fields
`define OCPWS_DRIVE_BIT 16
`define OCPWS_MODE_HI 2
`define OCPWS_MODE_LO 0
`define OCPWS_MODE_STOP 3'h1
`define OCPWS_MODE_IDLE 3'h3
// System control fields
`define OCPWS_PSRC_BIT 12
`define OCPWS_PRESCALER_DIVIDE_SELECT_HI 10
`define OCPWS_PRESCALER_DIVIDE_SELECT_LO 8
`define OCPWS_GEAR_HI 2
`define OCPWS_GEAR_LO 0
// PLL selection fields
`define OCPWS_PLL_USE_BIT 0
`define OCPWS_PLL_MULT_HI 10
`define OCPWS_PLL_MULT_LO 1
`define OCPWS_PLL_UPPER_HI 15
`define OCPWS_PLL_UPPER_LO 12
// Warm-up field value is scaled by sixteen source cycles
`define OCPWS_WU_SHIFT 4
`endif

// [core/ocpws_pkg.sv]
package ocpws_pkg;
   // Power state of the core
   typedef enum logic [1:0] {
      OCPWS_RUN  = 2'b00,
      OCPWS_IDLE = 2'b01,
      OCPWS_STOP = 2'b10,
      OCPWS_WARM = 2'b11
   } ocpws_state_t;
endpackage

// [core/ocpws_ctrl.sv]
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ocpws_map.svh"
// Function
// - Warm-up source bit: 0 internal, 1 external; aux bit 3 written 0.
// - Crystal pin switch: 0 port M function, 1 external oscillator pins.
// - Switch set blocks port M; refused while port M registers non-default.
// - Oscillator select: 0 internal, 1 external fast source.
// - Bit 16 enables internal oscillator, bit 8 enables external.
// - PLL run bit, 0 stop, 1 run, resets to 0.
// - Warm-up status reads 1 while counting, 0 when done.
// - Writing 1 to start bit launches warm-up; 0 does nothing.
// - Pin-drive bit keeps pins active in STOP when 1.
// - Mode field 001 STOP, 011 IDLE, taken on wait-for-interrupt.
// - PLL use bit: 0 oscillator clock, 1 PLL output; resets 0.
// - Gear divides fast clock 1..16; prescaler divides 1..32.
// - Reset: internal osc on, external off, PLL off, gear undivided.
// - STOP release by interrupt auto-starts warm-up, holds core halted.
// - Warm-up counts field value times sixteen source cycles.
// - Twelve-bit warm-up count field at bits 31 to 20.
// - Gear 000 undivided, 100..111 divide by 2,4,8,16.
// - Peripheral source: 0 gear clock, 1 undivided fast clock.
// - Prescaler codes 000..101 divide by 1..32.
module ocpws_ctrl (
   input wire logic ref_clk_i, // System clock, 125 MHz
   input wire logic srst_i, // Synchronous reset, active high
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB access phase
   input wire logic pwrite_i, // APB direction
   input wire logic [11:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error, unmapped address
   input wire logic portm_nondefault_i, // Port M control regs differ from reset
   input wire logic wfi_i, // Core executed wait-for-interrupt, pulse
   input wire logic wake_irq_i, // Release interrupt, pulse
   output logic crystal_pin_switch_o, // Crystal pins to oscillator, port M blocked
   output logic internal_osc_enable_o, // Internal oscillator runs
   output logic external_osc_enable_o, // External oscillator runs
   output logic osc_select_o, // Fast source: 1 external
   output logic pll_run_o, // PLL runs
   output logic pll_use_select_o, // Fast clock from PLL
   output logic [9:0] pll_multiplier_setting_o, // PLL multiplier field
   output logic [3:0] pll_setup_upper_o, // PLL upper setup field
   output logic [2:0] gear_shift_o, // Fast-to-gear divide exponent
   output logic peripheral_source_select_o, // Peripheral clock from fast clock
   output logic [2:0] prescaler_shift_o, // Prescaler divide exponent
   output logic warmup_source_select_o, // Warm-up counts external source
   output logic warmup_busy_o, // Warm-up timer running
   output logic stop_pin_drive_o, // Pins stay active in STOP
   output logic core_halt_o, // Processor held, system clock withheld
   output logic stop_mode_o // Device is in STOP
);

   // Warm-up is a count of source cycles, field times sixteen
   // Low four bits of the count are implied zero
   function automatic logic [15:0] wu_cycles(input logic [11:0] field);
      wu_cycles = {field, 4'h0};
   endfunction

   // Merges a bus write into a register, touching only its writable bits
   function automatic logic [31:0] merge_wr(input logic [31:0] old_val,
      input logic [31:0] wd, input logic [31:0] mask);
      merge_wr = (old_val & ~mask) | (wd & mask);
   endfunction

   // Exact offset compare; anything else is unmapped and answers with an error
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
      addr_hit = addr == off;
   endfunction

   // Register images, their next values and the bus answer flops
   logic [31:0] sys_reg, sys_next;
   logic [31:0] osc_reg, osc_next;
   logic [31:0] stby_reg, stby_next;
   logic [31:0] pll_reg, pll_next;
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [15:0] wu_cnt_reg, wu_cnt_next;
   logic wu_busy_reg, wu_busy_next;
   ocpws_pkg::ocpws_state_t state_reg, state_next;
   logic [2:0] gear_shift_reg;
   logic [2:0] presc_shift_reg;

   // Bus decode; the access completes one cycle after penable rises
   // Address, direction and data are held by the master until that edge
   wire access_w = psel_i & penable_i;
   wire commit_w = access_w & pready_reg;
   wire hit_sys_w = addr_hit(paddr_i, `OCPWS_SYSCTL_OFF);
   wire hit_osc_w = addr_hit(paddr_i, `OCPWS_OSCCTL_OFF);
   wire hit_stby_w = addr_hit(paddr_i, `OCPWS_STBYCTL_OFF);
   wire hit_pll_w = addr_hit(paddr_i, `OCPWS_PLL_USE_SELECT_OFF);
   wire mapped_w = hit_sys_w | hit_osc_w | hit_stby_w | hit_pll_w;
   wire wr_w = commit_w & pwrite_i;
   wire wr_sys_w = wr_w & hit_sys_w;
   wire wr_osc_w = wr_w & hit_osc_w;
   wire wr_stby_w = wr_w & hit_stby_w;
   wire wr_pll_w = wr_w & hit_pll_w;

   // Switch is refused while port M is configured; clearing always allowed
   // The port M block watches the switch output and locks its own registers
   wire xpin_refuse_w = pwdata_i[`OCPWS_XPIN_BIT] & ~osc_reg[`OCPWS_XPIN_BIT] &
      portm_nondefault_i;
   wire [31:0] osc_wdata_w = xpin_refuse_w ?
      {pwdata_i[31:19], 1'b0, pwdata_i[17:0]} : pwdata_i;

   // Masked writes keep read-only bits at their stored value
   // Reserved writable bits keep what software wrote, so they read back
   assign sys_next = wr_sys_w ?
      merge_wr(sys_reg, pwdata_i, `OCPWS_SYSCTL_WMASK) : sys_reg;
   assign osc_next = wr_osc_w ?
      merge_wr(osc_reg, osc_wdata_w, `OCPWS_OSCCTL_WMASK) : osc_reg;
   assign stby_next = wr_stby_w ?
      merge_wr(stby_reg, pwdata_i, `OCPWS_STBYCTL_WMASK) : stby_reg;
   assign pll_next = wr_pll_w ?
      merge_wr(pll_reg, pwdata_i, `OCPWS_PLL_USE_SELECT_WMASK) : pll_reg;

   // Read mux; status bit is live, start bit reads zero
   // Unmapped offsets read zero alongside the error flag
   wire [31:0] osc_rd_w = {osc_reg[31:2], wu_busy_reg, 1'b0};
   wire [31:0] rd_w = hit_sys_w ? sys_reg :
      hit_osc_w ? osc_rd_w :
      hit_stby_w ? stby_reg :
      hit_pll_w ? pll_reg : 32'h0000_0000;

   // Power mode sequencing
   // wfi and wake are one-cycle pulses from logic on this same clock
   wire [2:0] mode_w = stby_reg[`OCPWS_MODE_HI:`OCPWS_MODE_LO];
   wire warm_done_w = wu_busy_reg & (wu_cnt_reg == 16'h0001);
   wire sw_start_w = wr_osc_w & pwdata_i[`OCPWS_WU_START_BIT];
   wire stop_release_w = (state_reg == ocpws_pkg::OCPWS_STOP) & wake_irq_i;
   wire wu_start_w = sw_start_w | stop_release_w;
   // Count comes from the value being written, so one write can set it and start
   wire [15:0] wu_load_w = wu_cycles(osc_next[`OCPWS_WU_COUNT_HI:`OCPWS_WU_COUNT_LO]);

   // Next state for RUN, IDLE, STOP and the warm-up that follows STOP
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ocpws_pkg::OCPWS_RUN: begin
            // The mode chosen in the field is entered on wait-for-interrupt
            if (wfi_i && mode_w == `OCPWS_MODE_STOP) begin
               state_next = ocpws_pkg::OCPWS_STOP;
            end else if (wfi_i && mode_w == `OCPWS_MODE_IDLE) begin
               state_next = ocpws_pkg::OCPWS_IDLE;
            end
         end
         ocpws_pkg::OCPWS_IDLE: begin
            if (wake_irq_i) begin
               state_next = ocpws_pkg::OCPWS_RUN;
            end
         end
         ocpws_pkg::OCPWS_STOP: begin
            if (wake_irq_i) begin
               state_next = ocpws_pkg::OCPWS_WARM;
            end
         end
         ocpws_pkg::OCPWS_WARM: begin
            // A zero count ends at once rather than wrapping
            if (warm_done_w || !wu_busy_reg) begin
               state_next = ocpws_pkg::OCPWS_RUN;
            end
         end
         default: begin
            state_next = ocpws_pkg::OCPWS_RUN;
         end
      endcase
   end

   // Warm-up timer; a start in the finishing cycle restarts it
   // Each start reloads the count from the field; nothing carries over
   always_comb begin
      wu_cnt_next = wu_cnt_reg;
      wu_busy_next = wu_busy_reg;
      if (wu_start_w) begin
         wu_cnt_next = wu_load_w;
         wu_busy_next = wu_load_w != 16'h0000;
      end else if (warm_done_w) begin
         wu_cnt_next = 16'h0000;
         wu_busy_next = 1'b0;
      end else if (wu_busy_reg) begin
         wu_cnt_next = wu_cnt_reg - 16'h0001;
      end
   end

   // Gear code to divide exponent; reserved codes stay undivided
   wire [2:0] gear_w = sys_reg[`OCPWS_GEAR_HI:`OCPWS_GEAR_LO];
   wire [2:0] gear_shift_w = gear_w[2] ? {1'b0, gear_w[1:0]} + 3'h1 : 3'h0;
   // Prescaler code is the exponent; reserved codes hold at divide by 32
   wire [2:0] prescaler_divide_select_w = sys_reg[`OCPWS_PRESCALER_DIVIDE_SELECT_HI:`OCPWS_PRESCALER_DIVIDE_SELECT_LO];
   wire [2:0] presc_shift_w = (prescaler_divide_select_w > 3'h5) ? 3'h5 : prescaler_divide_select_w;

   // Bus handshake registers
   // One wait state keeps read data registered without a bypass path
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access_w & ~pready_reg;
         prdata_reg <= (access_w & ~pready_reg & ~pwrite_i) ? rd_w : 32'h0000_0000;
         pslverr_reg <= access_w & ~pready_reg & ~mapped_w;
      end
   end

   // Control registers; reset leaves the internal oscillator as the only clock
   // The external oscillator, the PLL and its use bit all come up off
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sys_reg <= `OCPWS_SYSCTL_RST;
         osc_reg <= `OCPWS_OSCCTL_RST;
         stby_reg <= `OCPWS_STBYCTL_RST;
         pll_reg <= `OCPWS_PLL_USE_SELECT_RST;
      end else begin
         sys_reg <= sys_next;
         osc_reg <= osc_next;
         stby_reg <= stby_next;
         pll_reg <= pll_next;
      end
   end

   // Warm-up and power state
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wu_cnt_reg <= 16'h0000;
         wu_busy_reg <= 1'b0;
         state_reg <= ocpws_pkg::OCPWS_RUN;
      end else begin
         wu_cnt_reg <= wu_cnt_next;
         wu_busy_reg <= wu_busy_next;
         state_reg <= state_next;
      end
   end

   // Decoded divider exponents, registered so outputs come from flops
   // Registering costs one cycle after a write, harmless to a clock divider
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         gear_shift_reg <= 3'h0;
         presc_shift_reg <= 3'h0;
      end else begin
         gear_shift_reg <= gear_shift_w;
         presc_shift_reg <= presc_shift_w;
      end
   end

   // Halt and STOP flags are registered from the next-state value, not the state flop
   // Following the next state lets halt rise on the edge that takes wfi
   wire halted_w = state_reg != ocpws_pkg::OCPWS_RUN;
   wire in_stop_w = state_reg == ocpws_pkg::OCPWS_STOP;
   logic core_halt_reg;
   logic stop_reg;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         core_halt_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         core_halt_reg <= state_next != ocpws_pkg::OCPWS_RUN;
         stop_reg <= state_next == ocpws_pkg::OCPWS_STOP;
      end
   end

   // Bus outputs
   // Error and data are registered with ready, so all three move together
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;

   // Clock tree controls straight from register fields; divider exponents come from their decode flops
   // The clock switching itself sits in the clock tree outside this block
   assign crystal_pin_switch_o = osc_reg[`OCPWS_XPIN_BIT];
   assign internal_osc_enable_o = osc_reg[`OCPWS_INT_EN_BIT];
   assign external_osc_enable_o = osc_reg[`OCPWS_EXT_EN_BIT];
   assign osc_select_o = osc_reg[`OCPWS_OSC_SEL_BIT];
   assign pll_run_o = osc_reg[`OCPWS_PLL_RUN_BIT];
   assign pll_use_select_o = pll_reg[`OCPWS_PLL_USE_BIT];
   assign pll_multiplier_setting_o = pll_reg[`OCPWS_PLL_MULT_HI:`OCPWS_PLL_MULT_LO];
   assign pll_setup_upper_o = pll_reg[`OCPWS_PLL_UPPER_HI:`OCPWS_PLL_UPPER_LO];
   assign gear_shift_o = gear_shift_reg;
   assign peripheral_source_select_o = sys_reg[`OCPWS_PSRC_BIT];
   assign prescaler_shift_o = presc_shift_reg;
   assign warmup_source_select_o = osc_reg[`OCPWS_WU_SRC_BIT];
   assign warmup_busy_o = wu_busy_reg;
   assign stop_pin_drive_o = stby_reg[`OCPWS_DRIVE_BIT];
   assign core_halt_o = core_halt_reg;
   assign stop_mode_o = stop_reg;

   // The state-flop mode flags drive nothing; they only feed an unused signal
   logic unused_ok;
   assign unused_ok = halted_w ^ in_stop_w;

endmodule

// [bench/ocpws_ctrl_props.sv]
`timescale 1ns/1ns
// Watches bus timing, warm-up launch and power-state outputs
module ocpws_ctrl_chk (
   input wire logic ref_clk_i, // Clock
   input wire logic srst_i, // Reset
   input wire logic psel_i, // Select
   input wire logic penable_i, // Access phase
   input wire logic pwrite_i, // Direction
   input wire logic [11:0] paddr_i, // Address
   input wire logic [31:0] pwdata_i, // Write data
   input wire logic [31:0] prdata_o, // Read data
   input wire logic pready_o, // Ready
   input wire logic pslverr_o, // Error
   input wire logic wfi_i, // Wait-for-interrupt
   input wire logic wake_irq_i, // Wake interrupt
   input wire logic warmup_busy_o, // Warm-up running
   input wire logic core_halt_o, // Core held
   input wire logic stop_mode_o // In STOP
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // Commit edge of a write to the oscillator register
   sequence s_osc_wr;
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h004;
   endsequence
   // First edge of an access phase
   sequence s_access;
      psel_i && $rose(penable_i);
   endsequence
   a_one_wait: assert property (s_access |-> !pready_o ##1 pready_o)
      else $error("ready not after one wait");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_decode_err: assert property (pready_o |->
      pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00C}))
      else $error("error flag wrong for address");
   a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside answer");
   a_start_launch: assert property (
      s_osc_wr ##0 (pwdata_i[0] && pwdata_i[31:20] != 12'h000) |=> warmup_busy_o)
      else $error("start write did not launch warm-up");
   a_zero_start: assert property (
      s_osc_wr ##0 (!pwdata_i[0] && !warmup_busy_o && !stop_mode_o) |=> !warmup_busy_o)
      else $error("zero start launched warm-up");
   a_stop_halts: assert property (stop_mode_o |-> core_halt_o)
      else $error("STOP without halt");
   a_stop_cause: assert property ($rose(stop_mode_o) |-> $past(wfi_i))
      else $error("STOP entered without wfi");
   a_wake_warm: assert property (
      stop_mode_o && wake_irq_i |=> !stop_mode_o && core_halt_o && warmup_busy_o)
      else $error("wake from STOP did not warm up");
   a_run_stays: assert property (!core_halt_o && !wfi_i |=> !core_halt_o)
      else $error("halt without wfi");
endmodule
bind ocpws_ctrl ocpws_ctrl_chk ocpws_ctrl_chk_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .wfi_i(wfi_i), .wake_irq_i(wake_irq_i), .warmup_busy_o(warmup_busy_o),
   .core_halt_o(core_halt_o), .stop_mode_o(stop_mode_o));

// [bench/test_osc_pll_warmup_standby_ctrl.sv]
`timescale 1ns/1ns
// Self-checking bench for the clock and standby controller
module test_osc_pll_warmup_standby_ctrl;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic portm_i = 1'b0, wfi_i = 1'b0, wake_i = 1'b0;
   logic [31:0] prdata_o, d;
   logic pready_o, pslverr_o, xpin, int_en, ext_en, osc_sel, pll_run, pll_use, psrc;
   logic wu_src, busy, drive, halt, stop;
   logic [9:0] mult;
   logic [3:0] upper;
   logic [2:0] gear, presc;
   logic [32:0] expq[$];
   int n_fail = 0, checks_done = 0, cycles = 0, seed = 97146, n;
   ocpws_ctrl ocpws_ctrl_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .portm_nondefault_i(portm_i), .wfi_i(wfi_i), .wake_irq_i(wake_i),
      .crystal_pin_switch_o(xpin), .internal_osc_enable_o(int_en),
      .external_osc_enable_o(ext_en), .osc_select_o(osc_sel), .pll_run_o(pll_run),
      .pll_use_select_o(pll_use), .pll_multiplier_setting_o(mult), .pll_setup_upper_o(upper),
      .gear_shift_o(gear), .peripheral_source_select_o(psrc), .prescaler_shift_o(presc),
      .warmup_source_select_o(wu_src), .warmup_busy_o(busy), .stop_pin_drive_o(drive),
      .core_halt_o(halt), .stop_mode_o(stop));
   // Free-running 125 MHz clock
   initial forever #4 ref_clk_i = ~ref_clk_i;
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One bus transfer; the answer expected is queued for the monitor
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] ex);
      expq.push_back(ex);
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      // Ready is sampled at each rising edge; release only after it is seen high
      @(posedge ref_clk_i);
      while (pready_o !== 1'b1) @(posedge ref_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Length of the next warm-up, waiting a few cycles for it to rise
   task busy_len(output int len);
      int k;
      len = 0;
      k = 0;
      @(negedge ref_clk_i);
      while (busy !== 1'b1 && k < 3) begin k++; @(negedge ref_clk_i); end
      while (busy === 1'b1 && len < 2000) begin len++; @(negedge ref_clk_i); end
   endtask
   task pulse(input bit w);
      @(posedge ref_clk_i);
      if (w) wfi_i <= 1'b1;
      else wake_i <= 1'b1;
      @(posedge ref_clk_i);
      wfi_i <= 1'b0;
      wake_i <= 1'b0;
   endtask
   // Error flag and read data answer every transfer in order
   always @(negedge ref_clk_i) begin
      if (pready_o === 1'b1) begin
         if (expq.size() == 0) chk(pready_o, 1'b0);
         else chk({pslverr_o, prdata_o}, expq.pop_front());
      end
   end
   // Cut a hang short; the whole sequence needs well under this
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 45000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({xpin, int_en, ext_en, osc_sel, pll_run, pll_use, gear, presc, busy, halt, stop},
         15'h2000);
      chk({upper, mult}, 14'h340F);
      apb(0, 12'h000, 0, {1'b0, 32'h0001_0000});
      apb(0, 12'h004, 0, {1'b0, 32'h8001_0000});
      apb(0, 12'h008, 0, {1'b0, 32'h0000_0103});
      apb(0, 12'h00C, 0, {1'b0, 32'h0000_D01E});
      apb(0, 12'h010, 0, {1'b1, 32'h0000_0000});
      apb(1, 12'h014, 32'hFFFF_FFFF, {1'b1, 32'h0000_0000});
      // Only the two legal PLL settings, written while the PLL is stopped and unused
      repeat (4) begin
         n = $random(seed);
         d = {16'h0000, 4'hD, 1'b0, n[0] ? 10'h113 : 10'h10F, 1'b0};
         apb(1, 12'h00C, d, 0);
         apb(0, 12'h00C, 0, {1'b0, d});
         chk({upper, mult, pll_use}, {d[15:12], d[10:0]});
      end
      // The PLL stays stopped over 100 us after a new multiplier
      repeat (12600) @(posedge ref_clk_i);
      // Port M not at reset: pin switch refused, the rest taken, 16-cycle warm-up
      @(posedge ref_clk_i);
      portm_i <= 1'b1;
      apb(1, 12'h004, 32'h001F_0105, 0);
      busy_len(n);
      chk(n, 16);
      chk({xpin, wu_src, osc_sel, int_en, ext_en, pll_run}, 6'h1F);
      apb(0, 12'h004, 0, {1'b0, 32'h001B_0104});
      portm_i <= 1'b0;
      apb(1, 12'h004, 32'h001F_0104, 0);
      @(negedge ref_clk_i);
      chk({xpin, busy}, 2'b10);
      // External clock confirmed, then the internal oscillator goes off for good
      apb(0, 12'h004, 0, {1'b0, 32'h001F_0104});
      apb(1, 12'h004, 32'h001E_0104, 0);
      @(negedge ref_clk_i);
      chk({int_en, osc_sel, ext_en}, 3'b011);
      // Lock time before the multiplied clock is taken into use
      repeat (25100) @(posedge ref_clk_i);
      apb(1, 12'h00C, d | 32'h0000_0001, 0);
      apb(0, 12'h00C, 0, {1'b0, d | 32'h0000_0001});
      chk(pll_use, 1'b1);
      // Every gear code with random prescaler and source fields
      for (int i = 0; i < 8; i++) begin
         d = $random(seed) & 32'h0003_1707;
         d[2:0] = i[2:0];
         apb(1, 12'h000, d, 0);
         apb(0, 12'h000, 0, {1'b0, d});
         chk(gear, d[2] ? d[1:0] + 3'h1 : 3'h0);
         chk(presc, d[10:8] > 3'h5 ? 3'h5 : d[10:8]);
         chk(psrc, d[12]);
      end
      // STOP, then auto warm-up on wake
      apb(1, 12'h008, 32'h0001_0101, 0);
      pulse(1);
      @(negedge ref_clk_i);
      chk({drive, halt, stop}, 3'b111);
      pulse(0);
      busy_len(n);
      chk({n, halt}, {32'd16, 1'b0});
      // IDLE, then a reserved code that wfi must ignore
      apb(1, 12'h008, 32'h0001_0103, 0);
      pulse(1);
      @(negedge ref_clk_i);
      chk({halt, stop}, 2'b10);
      pulse(0);
      @(negedge ref_clk_i);
      chk(halt, 1'b0);
      apb(1, 12'h008, 32'h0001_0100, 0);
      pulse(1);
      @(negedge ref_clk_i);
      chk(halt, 1'b0);
      apb(0, 12'h008, 0, {1'b0, 32'h0001_0100});
      tally_and_finish();
   end
endmodule
